// >>> design/jrx_consts.svh
// Register offsets, field widths and reset values of the lane block
`ifndef JRX_CONSTS_SVH
`define JRX_CONSTS_SVH
`define JRX_ADDR_W 12
`define JRX_OFS_LAT0 12'h302
`define JRX_OFS_LAT1 12'h303
`define JRX_OFS_DEL0 12'h304
`define JRX_OFS_DEL1 12'h305
`define JRX_OFS_REL0 12'h306
`define JRX_OFS_REL1 12'h307
`define JRX_OFS_XBAR0 12'h308
`define JRX_OFS_XBAR1 12'h309
`define JRX_OFS_XBAR2 12'h30A
`define JRX_OFS_XBAR3 12'h30B
`define JRX_OFS_FULL 12'h30C
`define JRX_FIELD_W 5
`define JRX_SEL_W 3
`define JRX_DEL_RST 5'h00
`define JRX_REL_RST 5'h06
`define JRX_REL_MAX 5'h0A
`endif

// >>> design/jrx_lane_xbar.sv
// Lane crossbar, link timing control and register port of the receiver
//
// Function
// - Link 0, and link 1 in two-link operation, report a read-only 5-bit measured delayed-global-to-deframer LMFC latency.
// - Link 1 latency has its own readout at offset 0x303.
// - Link 0 global LMFC delayed by 5-bit frame-cycle field, reset zero.
// - Link 1 global LMFC delayed by its own independent 5-bit field.
// - Each link releases buffer words at 5-bit position, reset six.
// - Each logical lane takes the physical input named by its select.
// - After reset each lane selects the input of its own number.
// - Bit x of the full field is high when lane x buffer is full.
// - Full flags are error indications visible to software.
// - Link 1 settings act only when two-link operation is selected.
`timescale 1ns/10ps
`include "jrx_consts.svh"
module jrx_lane_xbar import jrx_pkg::*; #(
  parameter int LANES = 8,
  parameter int DATA_W = 32,
  parameter int LMFC_LEN = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Mode
  input wire logic two_link_select,
  // Physical serial inputs, words already deserialised
  input wire logic [LANES*DATA_W-1:0] physical_serial_input,
  // Lane buffer status
  input wire logic [LANES-1:0] lane_buffer_full,
  // Multiframe timing
  input wire logic global_lmfc,
  input wire logic [1:0] deframer_lmfc,
  // Outputs
  output logic [LANES*DATA_W-1:0] logical_lane_data,
  output logic [1:0] release_strobe,
  output logic [1:0] buffer_full_error
);
  // Register map and readback are laid out for eight lanes
  if (LANES != 8 || DATA_W < 1) begin : g_bad_cfg
    $error("crossbar serves eight lanes only");
  end

  jrx_sel_t lane_source [LANES];
  jrx_field_t link0_global_delay;
  jrx_field_t link1_global_delay;
  jrx_field_t link0_release_point;
  jrx_field_t link1_release_point;
  jrx_field_t link0_latency_readout;
  jrx_field_t link1_latency_readout;
  logic [1:0] rel_pulse;
  logic [7:0] full_q;
  logic [7:0] next_rdata;
  logic link1_on;

  assign link1_on = two_link_select;

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link0_global_delay <= `JRX_DEL_RST;
      link1_global_delay <= `JRX_DEL_RST;
      link0_release_point <= `JRX_REL_RST;
      link1_release_point <= `JRX_REL_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `JRX_OFS_DEL0: link0_global_delay <= reg_wdata[4:0];
        `JRX_OFS_DEL1: link1_global_delay <= reg_wdata[4:0];
        `JRX_OFS_REL0: link0_release_point <= reg_wdata[4:0];
        `JRX_OFS_REL1: link1_release_point <= reg_wdata[4:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Crossbar
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      localparam logic [11:0] OFS = `JRX_OFS_XBAR0 + 12'(g / 2);
      localparam int SH = (g % 2) * 3;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          lane_source[g] <= 3'(g);
        end else if (reg_wr && reg_addr == OFS) begin
          lane_source[g] <= reg_wdata[SH +: 3];
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          logical_lane_data[g*DATA_W +: DATA_W] <= '0;
        end else begin
          logical_lane_data[g*DATA_W +: DATA_W] <=
            physical_serial_input[lane_source[g]*DATA_W +: DATA_W];
        end
      end
    end
  endgenerate

  // ****************************************
  // Link timing
  // ****************************************
  jrx_link_timing #(.LMFC_LEN(LMFC_LEN)) u_link0 (
    .clk(clk),
    .rst(rst),
    .enable(1'b1),
    .global_delay(link0_global_delay),
    .release_point(link0_release_point),
    .global_lmfc(global_lmfc),
    .deframer_lmfc(deframer_lmfc[0]),
    .release_pulse(rel_pulse[0]),
    .latency(link0_latency_readout)
  );
  jrx_link_timing #(.LMFC_LEN(LMFC_LEN)) u_link1 (
    .clk(clk),
    .rst(rst),
    .enable(link1_on),
    .global_delay(link1_global_delay),
    .release_point(link1_release_point),
    .global_lmfc(global_lmfc),
    .deframer_lmfc(deframer_lmfc[1]),
    .release_pulse(rel_pulse[1]),
    .latency(link1_latency_readout)
  );

  // Registered so every output comes from a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      release_strobe <= 2'h0;
      full_q <= 8'h00;
      buffer_full_error <= 2'h0;
    end else begin
      release_strobe <= {rel_pulse[1] & link1_on, rel_pulse[0]};
      full_q <= lane_buffer_full;
      // Lanes 0-3 carry link 0 in dual mode, all lanes otherwise
      buffer_full_error[0] <= link1_on ? |lane_buffer_full[3:0]
                                       : |lane_buffer_full;
      buffer_full_error[1] <= link1_on & |lane_buffer_full[7:4];
    end
  end

  // ****************************************
  // Readback
  // ****************************************
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      `JRX_OFS_LAT0: next_rdata = {3'h0, link0_latency_readout};
      `JRX_OFS_LAT1: next_rdata = {3'h0, link1_latency_readout};
      `JRX_OFS_DEL0: next_rdata = {3'h0, link0_global_delay};
      `JRX_OFS_DEL1: next_rdata = {3'h0, link1_global_delay};
      `JRX_OFS_REL0: next_rdata = {3'h0, link0_release_point};
      `JRX_OFS_REL1: next_rdata = {3'h0, link1_release_point};
      `JRX_OFS_XBAR0: next_rdata = {2'h0, lane_source[1], lane_source[0]};
      `JRX_OFS_XBAR1: next_rdata = {2'h0, lane_source[3], lane_source[2]};
      `JRX_OFS_XBAR2: next_rdata = {2'h0, lane_source[5], lane_source[4]};
      `JRX_OFS_XBAR3: next_rdata = {2'h0, lane_source[7], lane_source[6]};
      `JRX_OFS_FULL: next_rdata = full_q;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking xb_cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // A read of the flags, then the cycle in which its data stands
  sequence s_full_read;
    reg_rd && reg_addr == `JRX_OFS_FULL ##1 1'b1;
  endsequence

  chk_full_flag_live: assert property (
    s_full_read |-> reg_rdata == $past(lane_buffer_full, 2))
    else $error("full flags not live");
  chk_lat_reserved_zero: assert property (
    reg_rd && reg_addr == `JRX_OFS_LAT1 |=> reg_rdata[7:5] == 3'h0)
    else $error("reserved bits not zero");
  chk_link1_off_quiet: assert property (
    !two_link_select |=> !release_strobe[1])
    else $error("link 1 active in single mode");
  chk_xbar_route: assert property (
    $stable(lane_source[3]) |=> logical_lane_data[3*DATA_W +: DATA_W] ==
      $past(physical_serial_input[lane_source[3]*DATA_W +: DATA_W]))
    else $error("lane 3 misrouted");
  chk_delay_write: assert property (
    reg_wr && reg_addr == `JRX_OFS_DEL0
    |=> link0_global_delay == $past(reg_wdata[4:0]))
    else $error("delay 0 not written");
  chk_delay1_sep: assert property (
    reg_wr && reg_addr == `JRX_OFS_DEL0 |=> $stable(link1_global_delay))
    else $error("delay 1 disturbed");
  chk_lat_ro: assert property (
    reg_wr && reg_addr == `JRX_OFS_LAT0 |=> $stable(link0_release_point))
    else $error("latency write leaked");
  chk_full_error: assert property (
    |lane_buffer_full[3:0] |=> buffer_full_error[0])
    else $error("full error missed");
  chk_full_error_all: assert property (
    !two_link_select && |lane_buffer_full |=> buffer_full_error[0])
    else $error("single link full error missed");
  chk_full_error_hi: assert property (
    two_link_select && |lane_buffer_full[7:4] |=> buffer_full_error[1])
    else $error("link 1 full error missed");
  chk_release_write: assert property (
    reg_wr && reg_addr == `JRX_OFS_REL0
    |=> link0_release_point == $past(reg_wdata[4:0]))
    else $error("release point 0 not written");
  chk_rdata_stands: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
endmodule

// >>> design/jrx_link_timing.sv
// Per-link global multiframe delay, release point and latency measurement
`timescale 1ns/10ps
`include "jrx_consts.svh"
module jrx_link_timing import jrx_pkg::*; #(
  parameter int LMFC_LEN = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire logic [4:0] global_delay,
  input wire logic [4:0] release_point,
  // Timing pulses
  input wire logic global_lmfc,
  input wire logic deframer_lmfc,
  // Results
  output logic release_pulse,
  output logic [4:0] latency
);
  // Phase counter is five bits wide and shift line 32 stages deep
  if (LMFC_LEN < 2 || LMFC_LEN > 32) begin : g_bad_len
    $error("LMFC_LEN out of range");
  end

  logic [31:0] dly_line;
  logic [4:0] phase;
  logic [4:0] lat_cnt;
  logic counting;
  logic delayed_lmfc;

  // Delayed global LMFC: tap of a shift line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dly_line <= 32'h0;
    end else begin
      dly_line <= {dly_line[30:0], global_lmfc};
    end
  end
  assign delayed_lmfc = (global_delay == 5'h00) ? global_lmfc :
                        dly_line[global_delay - 5'h01];

  // Phase in the local multiframe, restarted by delayed global LMFC
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= 5'h00;
      release_pulse <= 1'b0;
    end else begin
      release_pulse <= enable && (phase == release_point);
      if (!enable || delayed_lmfc)
        phase <= 5'h00;
      else
        phase <= phase + 5'h01;
    end
  end

  // Latency: cycles from delayed global LMFC to deframer LMFC
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lat_cnt <= 5'h00;
      counting <= 1'b0;
      latency <= 5'h00;
    end else if (!enable) begin
      counting <= 1'b0;
      latency <= 5'h00;
    end else begin
      if (delayed_lmfc && deframer_lmfc) begin
        latency <= 5'h00;
        counting <= 1'b0;
      end else if (delayed_lmfc) begin
        lat_cnt <= 5'h01;
        counting <= 1'b1;
      end else if (counting && deframer_lmfc) begin
        latency <= lat_cnt;
        counting <= 1'b0;
      end else if (counting) begin
        lat_cnt <= lat_cnt + 5'h01;
      end
    end
  end

  default clocking lt_cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_at_release;
    enable && phase == release_point && $stable(enable);
  endsequence

  chk_release_on_phase: assert property (
    s_at_release |=> release_pulse)
    else $error("release pulse missing");
endmodule

// >>> design/jrx_pkg.sv
// Types shared by the lane block
package jrx_pkg;
  typedef logic [4:0] jrx_field_t;
  typedef logic [2:0] jrx_sel_t;
endpackage

// >>> dv/jrx_lane_xbar_bench.sv
// Self-checking bench of the lane crossbar and link timing block
`timescale 1ns/10ps
`include "jrx_consts.svh"
module jrx_lane_xbar_bench;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, two = 0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, full = 8'h00, v;
  logic [255:0] phys, ldata, p;
  logic glmfc;
  logic [1:0] dlmfc, rel, ferr;
  int fails = 0, checks_done = 0, n6, n9;
  always #25 clk = ~clk;
  jrx_tx_model tx_u (.clk(clk), .rst(rst), .lanes(phys),
    .global_lmfc(glmfc), .deframer_lmfc(dlmfc));
  jrx_lane_xbar dut_u (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .two_link_select(two),
    .physical_serial_input(phys), .lane_buffer_full(full),
    .global_lmfc(glmfc), .deframer_lmfc(dlmfc),
    .logical_lane_data(ldata), .release_strobe(rel),
    .buffer_full_error(ferr));
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(negedge clk);
    reg_rd = 1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 0;
    v = reg_rdata;
  endtask
  task automatic meas(output int n);
    int k;
    k = 0;
    n = 0;
    @(negedge clk);
    while (dlmfc[0] !== 1'b1 && k < 99) begin
      @(negedge clk);
      k++;
    end
    while (rel[0] !== 1'b1 && n < 99) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    rd(`JRX_OFS_DEL0); chk(v, 8'h00);
    rd(`JRX_OFS_REL0); chk(v, 8'h06);
    rd(`JRX_OFS_REL1); chk(v, 8'h06);
    rd(`JRX_OFS_DEL1); chk(v, 8'h00);
    rd(`JRX_OFS_LAT1); chk(v, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(`JRX_OFS_XBAR0 + 12'(i));
      chk(v, {2'b00, 3'(2*i+1), 3'(2*i)});
    end
    rd(12'h3FF); chk(v, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_regs;
    wr(`JRX_OFS_DEL1, 8'hFF);
    rd(`JRX_OFS_DEL1); chk(v, 8'h1F);
    wr(`JRX_OFS_FULL, 8'hFF);
    rd(`JRX_OFS_FULL); chk(v, 8'h00);
    wr(`JRX_OFS_LAT0, 8'hFF);
    rd(`JRX_OFS_REL0); chk(v, 8'h06);
    wr(`JRX_OFS_DEL1, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_xbar;
    @(negedge clk);
    p = phys;
    @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      chk(ldata[i*32+:32], p[i*32+:32]);
    end
    wr(`JRX_OFS_XBAR1, 8'hDA);
    rd(`JRX_OFS_XBAR1); chk(v, 8'h1A);
    wr(`JRX_OFS_XBAR0, 8'h17);
    wr(`JRX_OFS_XBAR3, 8'h00);
    @(negedge clk);
    p = phys;
    @(negedge clk);
    chk(ldata[0+:32], p[224+:32]);
    chk(ldata[32+:32], p[64+:32]);
    chk(ldata[96+:32], p[96+:32]);
    chk(ldata[224+:32], p[0+:32]);
    $display("test xbar done");
  endtask
  task automatic t_full;
    full = 8'h5A;
    rd(`JRX_OFS_FULL); chk(v, 8'h5A);
    chk(ferr, 2'b01);
    two = 1;
    full = 8'h10;
    repeat (3) @(negedge clk);
    chk(ferr, 2'b10);
    full = 8'h00;
    $display("test full done");
  endtask
  task automatic t_lat;
    two = 0;
    repeat (80) @(negedge clk);
    rd(`JRX_OFS_LAT0); chk(v, 8'h09);
    wr(`JRX_OFS_DEL0, 8'h02);
    wr(`JRX_OFS_DEL1, 8'h05);
    repeat (80) @(negedge clk);
    rd(`JRX_OFS_LAT0); chk(v, 8'h07);
    rd(`JRX_OFS_LAT1); chk(v, 8'h00);
    two = 1;
    repeat (80) @(negedge clk);
    rd(`JRX_OFS_LAT1); chk(v, 8'h08);
    rd(`JRX_OFS_LAT0); chk(v, 8'h07);
    $display("test latency done");
  endtask
  task automatic t_rel;
    int c;
    c = 0;
    meas(n6);
    wr(`JRX_OFS_REL0, 8'h09);
    meas(n9);
    chk(32'((n9 - n6 + 32) % 32), 32'd3);
    // Two multiframes in dual mode: exactly two link 1 releases
    repeat (64) begin
      @(negedge clk);
      if (rel[1] === 1'b1) c++;
    end
    chk(32'(c), 32'd2);
    c = 0;
    two = 0;
    repeat (70) begin
      @(negedge clk);
      if (rel[1] !== 1'b0) c++;
    end
    chk(32'(c), 32'd0);
    $display("test release done");
  endtask
  initial begin
    #1000000;
    fails++;
    final_report();
  end
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    t_reset();
    t_regs();
    t_xbar();
    t_full();
    t_lat();
    t_rel();
    final_report();
  end
endmodule

// >>> dv/jrx_tx_model.sv
// Transmitter-side model: lane words and multiframe pulses
`timescale 1ns/10ps
module jrx_tx_model #(
  parameter int LANES = 8,
  parameter int DATA_W = 32,
  parameter int LMFC_LEN = 32,
  parameter int OFS0 = 9,
  parameter int OFS1 = 13
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Toward the receiver
  output logic [LANES*DATA_W-1:0] lanes,
  output logic global_lmfc,
  output logic [1:0] deframer_lmfc
);
  logic [15:0] tick;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) tick <= 16'h0000;
    else tick <= tick + 16'h0001;
  end
  // Words change every cycle, so a stale or wrong lane shows
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      lanes[i*DATA_W+:DATA_W] = DATA_W'({8'(i), tick});
    end
  end
  assign global_lmfc = (tick % LMFC_LEN) == 0;
  assign deframer_lmfc[0] = (tick % LMFC_LEN) == OFS0;
  assign deframer_lmfc[1] = (tick % LMFC_LEN) == OFS1;
endmodule
